//--- tfh_ctl.sv
// Our own choices: the plain strobed port and the register addresses.
`timescale 1ns/10ps
module tfh_ctl import tfh_pkg::*; (
   input wire logic clk_i, // 25 MHz
   input wire logic resetn_i, // Async, active low
   input wire logic [7:0] sw_addr_i, // Byte address
   input wire logic [31:0] sw_wdata_i, // Write data
   input wire logic sw_wr_i, // Write strobe
   input wire logic sw_rd_i, // Read strobe
   output logic [31:0] sw_rdata_o, // Read data, cycle after strobe
   output logic busy_o, // Sequence running
   output logic dev_wr_o, // Device register write
   output logic [13:0] dev_addr_o, // Device register offset
   output logic [31:0] dev_data_o // Device register data
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!resetn_i);

   logic [31:0] ctrl_reg, pat_lo_reg, pat_hi_reg, foreground_color_reg_reg, background_color_reg_reg, tex_reg;
   logic [5:0] shift_reg;
   logic [31:0] param_reg [N_PARAM];
   tfh_state_t state_reg;
   tfh_step_t step_reg;
   logic done_reg, split_reg;
   logic [4:0] err_reg;
   logic [31:0] rdata_reg;

   function automatic logic same_bytes(input logic [31:0] c);
      return (c[31:24] == c[23:16]) && (c[23:16] == c[15:8]) && (c[15:8] == c[7:0]);
   endfunction
   function automatic logic pow2_mask(input logic [10:0] m);
      return (m & (m + 11'h001)) == 11'h000;
   endfunction

   tfh_mode_t mode;
   logic [2:0] atype, texel;
   logic [1:0] pw;
   logic [10:0] wmask, hmask;
   logic [8:0] pext;
   logic [63:0] pat64;
   logic is_blk, pixel_24bpp, shaded, textured, interp, transc_eff, pat_le, zw;
   logic e_fmt24, e_pat24, e_atype, e_pal, e_mask, split_adv, any_err;
   logic cfg_wr, start;

   assign mode = tfh_mode_t'(ctrl_reg[C_MODE+:3]);
   assign atype = ctrl_reg[C_ATYPE+:3];
   assign pw = ctrl_reg[C_PW+:2];
   assign texel = ctrl_reg[C_TEXEL+:3];
   assign wmask = tex_reg[T_WM+:11];
   assign hmask = tex_reg[T_HM+:11];
   assign pext = tex_reg[T_PEXT+:9];
   assign pat64 = {pat_hi_reg, pat_lo_reg};
   assign is_blk = atype == AT_BLK;
   assign pixel_24bpp = pw == PW_24;
   assign shaded = mode == M_GOUR;
   assign textured = (mode == M_TEX) || (mode == M_SCAL);
   assign interp = shaded || textured;
   assign pat_le = ctrl_reg[C_LE];
   assign zw = ctrl_reg[C_ZW];
   // Opaque background cannot be drawn with block write, so force it off
   assign transc_eff = ctrl_reg[C_TRC] || is_blk;

   assign e_fmt24 = interp && pixel_24bpp;
   assign e_pat24 = (mode == M_PAT) && pixel_24bpp && (atype != AT_RASTER_ACCESS) &&
                    !(same_bytes(foreground_color_reg_reg) && same_bytes(background_color_reg_reg));
   assign e_atype = interp && !((atype == AT_ZI) || (atype == AT_I));
   assign e_pal = textured && ((texel == TX_4) || (texel == TX_8)) &&
                  !ctrl_reg[C_PAL];
   assign e_mask = textured && ((ctrl_reg[C_MIP] && ((wmask[3:0] != MIP_LOW) ||
                   (hmask[3:0] != MIP_LOW) || (pext[3:0] != 4'h0))) ||
                   (!tex_reg[T_CLAMP] && !(pow2_mask(wmask) && pow2_mask(hmask))));
   // Only advisory: the fill still runs, software decides whether to split
   assign split_adv = textured && ctrl_reg[C_BIL] && ({1'b0, wmask} >= SPLIT_TEXELS) &&
                      ((texel == TX_32) || (texel == TX_YUV));
   assign any_err = e_fmt24 || e_pat24 || e_atype || e_pal || e_mask;

   // Setup is frozen while a sequence runs so the device sees one snapshot
   assign cfg_wr = sw_wr_i && (state_reg == ST_IDLE);
   assign start = cfg_wr && (sw_addr_i == A_CMD) && sw_wdata_i[0];

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ctrl_reg <= CTRL_RST;
         pat_lo_reg <= '0;
         pat_hi_reg <= '0;
         foreground_color_reg_reg <= '0;
         background_color_reg_reg <= '0;
         tex_reg <= '0;
         shift_reg <= '0;
      end else if (cfg_wr) begin
         unique case (sw_addr_i)
            A_CTRL: ctrl_reg <= sw_wdata_i;
            A_PATL: pat_lo_reg <= sw_wdata_i;
            A_PATH: pat_hi_reg <= sw_wdata_i;
            A_FOREGROUND_COLOR_REG: foreground_color_reg_reg <= sw_wdata_i;
            A_BACKGROUND_COLOR_REG: background_color_reg_reg <= sw_wdata_i;
            A_TEX: tex_reg <= sw_wdata_i;
            A_SHIFT: shift_reg <= sw_wdata_i[5:0];
            default: ;
         endcase
      end
   end

   for (genvar g = 0; g < N_PARAM; g++) begin : g_param
      always_ff @(posedge clk_i or negedge resetn_i) begin
         if (!resetn_i) begin
            param_reg[g] <= '0;
         end else if (cfg_wr && (sw_addr_i == A_PARAM + 8'(4 * g))) begin
            param_reg[g] <= sw_wdata_i;
         end
      end
   end

   logic [31:0] dwg;
   always_comb begin
      dwg = '0;
      dwg[W_OP+:4] = textured ? OP_TEXTRAP : OP_TRAP;
      dwg[W_AT+:3] = atype;
      dwg[W_ZM+:3] = interp ? ctrl_reg[C_ZMODE+:3] : 3'h0;
      dwg[W_SOLID] = mode == M_PLAIN;
      dwg[W_ARZ] = ctrl_reg[C_RECTANGLE_FILL];
      dwg[W_SGZ] = ctrl_reg[C_RECTANGLE_FILL];
      dwg[W_SHZ] = (mode == M_PAT) ? ctrl_reg[C_SHZ] : 1'b1;
      dwg[W_BOP+:4] = is_blk ? BOP_BLK : ctrl_reg[C_BOP+:4];
      dwg[W_TRC] = (mode == M_PLAIN) || ((mode == M_PAT) && transc_eff);
   end

   logic need;
   logic [13:0] daddr;
   logic [31:0] ddata;
   always_comb begin
      int k, j, zi;
      k = int'(step_reg);
      j = 0;
      zi = 0;
      need = 1'b0;
      daddr = D_DWG;
      ddata = '0;
      if (step_reg == P_MACC) begin
         need = 1'b1;
         daddr = D_MACC;
         ddata = {30'h0, pw};
      end else if (step_reg <= P_PATTERN_WORD_HIGH) begin
         need = (mode == M_PAT) && !pat_le;
         daddr = (step_reg == P_PATTERN_WORD_LOW) ? D_PATTERN_WORD_LOW : D_PATTERN_WORD_HIGH;
         ddata = (step_reg == P_PATTERN_WORD_LOW) ? pat_lo_reg : pat_hi_reg;
      end else if (step_reg < P_SHIFT) begin
         j = k - int'(P_SRC);
         need = (mode == M_PAT) && pat_le;
         daddr = D_PATTERN_SOURCE_WORD_A + 14'(4 * j);
         // Each line doubled so the device can wrap the offset across it
         ddata = {pat64[16*j+8+:8], pat64[16*j+8+:8],
                  pat64[16*j+:8], pat64[16*j+:8]};
      end else if (step_reg == P_SHIFT) begin
         need = (mode == M_PAT) && !ctrl_reg[C_SHZ];
         daddr = D_SHIFT;
         ddata = {26'h0, shift_reg};
      end else if (step_reg == P_BACKGROUND_COLOR_REG) begin
         need = (mode == M_PAT) && !transc_eff;
         daddr = D_BACKGROUND_COLOR_REG;
         ddata = background_color_reg_reg;
      end else if (step_reg == P_FOREGROUND_COLOR_REG) begin
         need = 1'b1;
         daddr = D_FOREGROUND_COLOR_REG;
         ddata = foreground_color_reg_reg;
      end else if (step_reg < P_Z) begin
         j = k - int'(P_RGB);
         need = shaded || (textured && ctrl_reg[C_TFN]);
         zi = 4 + 4 * (j / 3) + ((j % 3 == 0) ? 0 : (j % 3) + 1);
         daddr = D_DR0 + 14'(4 * zi);
         ddata = param_reg[PI_RGB+j];
      end else if (step_reg < P_FOG) begin
         j = (step_reg < P_ZHI) ? k - int'(P_Z) : k - int'(P_ZHI);
         zi = (j == 0) ? 0 : j + 1;
         need = interp && (ctrl_reg[C_ZCMP] || (atype == AT_ZI)) &&
                ((step_reg < P_ZHI) || zw);
         if (step_reg >= P_ZHI) begin
            daddr = D_Z32 + 14'(8 * zi + 4);
            ddata = param_reg[PI_ZHI+j];
         end else begin
            daddr = zw ? D_Z32 + 14'(8 * zi) : D_DR0 + 14'(4 * zi);
            ddata = param_reg[PI_Z+j];
         end
      end else if (step_reg < P_TEXTURE_BASE_ORIGIN) begin
         j = k - int'(P_FOG);
         need = interp && ctrl_reg[C_FOG];
         daddr = D_FOG + 14'(4 * j);
         ddata = param_reg[PI_FOG+j];
      end else if (step_reg == P_TEXTURE_BASE_ORIGIN) begin
         need = textured;
         daddr = D_TEXTURE_BASE_ORIGIN;
         ddata = param_reg[PI_TEXTURE_BASE_ORIGIN];
      end else if (step_reg < P_DWG) begin
         j = k - int'(P_PERSP);
         need = mode == M_SCAL;
         daddr = (j == 0) ? D_PERSP_INC_X : ((j == 1) ? D_PERSP_INC_Y : D_PERSP_START);
         ddata = (j == 2) ? PERSP_START : PERSP_ZERO;
      end else begin
         need = 1'b1;
         daddr = D_DWG + D_ALIAS;
         ddata = dwg;
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state_reg <= ST_IDLE;
         step_reg <= P_MACC;
      end else begin
         unique case (state_reg)
            ST_IDLE: begin
               step_reg <= P_MACC;
               if (start && !any_err) begin
                  state_reg <= ST_RUN;
               end
            end
            ST_RUN: begin
               step_reg <= step_reg + 6'h01;
               if (step_reg == P_DWG) begin
                  state_reg <= ST_IDLE;
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         dev_wr_o <= 1'b0;
         dev_addr_o <= '0;
         dev_data_o <= '0;
      end else begin
         dev_wr_o <= (state_reg == ST_RUN) && need;
         if ((state_reg == ST_RUN) && need) begin
            dev_addr_o <= daddr;
            dev_data_o <= ddata;
         end
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         err_reg <= '0;
         split_reg <= 1'b0;
      end else if (start) begin
         err_reg <= {e_mask, e_pal, e_atype, e_pat24, e_fmt24};
         split_reg <= split_adv;
      end
   end

   // Completion wins over a clear arriving in the same cycle
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         done_reg <= 1'b0;
      end else if ((state_reg == ST_RUN) && (step_reg == P_DWG)) begin
         done_reg <= 1'b1;
      end else if (sw_wr_i && (sw_addr_i == A_STAT) && sw_wdata_i[S_DONE]) begin
         done_reg <= 1'b0;
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rdata_reg <= '0;
      end else if (sw_rd_i) begin
         rdata_reg <= '0;
         if (sw_addr_i >= A_PARAM && sw_addr_i < A_PARAM + 8'(4 * N_PARAM) &&
             sw_addr_i[1:0] == 2'h0) begin
            rdata_reg <= param_reg[5'((sw_addr_i - A_PARAM) >> 2)];
         end
         unique case (sw_addr_i)
            A_CTRL: rdata_reg <= ctrl_reg;
            A_STAT: rdata_reg <= {24'h0, split_reg, err_reg, done_reg,
                                  state_reg == ST_RUN};
            A_PATL: rdata_reg <= pat_lo_reg;
            A_PATH: rdata_reg <= pat_hi_reg;
            A_FOREGROUND_COLOR_REG: rdata_reg <= foreground_color_reg_reg;
            A_BACKGROUND_COLOR_REG: rdata_reg <= background_color_reg_reg;
            A_TEX: rdata_reg <= tex_reg;
            A_SHIFT: rdata_reg <= {26'h0, shift_reg};
            default: ;
         endcase
      end
   end

   assign sw_rdata_o = rdata_reg;
   assign busy_o = state_reg == ST_RUN;

   a_final_alias: assert property (
      (state_reg == ST_RUN && step_reg == P_DWG) |=>
         dev_wr_o && dev_addr_o == D_RNG_LO && state_reg == ST_IDLE && done_reg)
      else $error("final write missing or outside alias range");
   a_alias_only_last: assert property (
      (dev_wr_o && dev_addr_o >= D_RNG_LO && dev_addr_o <= D_RNG_HI) |->
         $past(step_reg) == P_DWG)
      else $error("alias range written before the final step");
   a_run_length: assert property (
      $rose(state_reg == ST_RUN) |-> ##33 (step_reg == P_DWG) ##1 (state_reg == ST_IDLE))
      else $error("setup sequence length wrong");
   a_shift_gate: assert property (
      (dev_wr_o && dev_addr_o == D_SHIFT) |-> !ctrl_reg[C_SHZ] && mode == M_PAT)
      else $error("offset loaded while shift-zero set");
   a_blk_transc: assert property (
      (state_reg == ST_RUN && step_reg == P_DWG && mode == M_PAT && is_blk) |=>
         dev_data_o[W_TRC] && dev_data_o[W_BOP+:4] == BOP_BLK)
      else $error("block write pattern fill left opaque");
   a_persp_start: assert property (
      (dev_wr_o && dev_addr_o == D_PERSP_INC_X) |-> (dev_data_o == PERSP_ZERO) ##1
         (dev_wr_o && dev_addr_o == D_PERSP_INC_Y && dev_data_o == PERSP_ZERO) ##1
         (dev_wr_o && dev_addr_o == D_PERSP_START && dev_data_o == PERSP_START))
      else $error("scaler perspective values wrong");
   a_no_24bpp_run: assert property (
      (state_reg == ST_RUN && interp) |-> !pixel_24bpp && !e_atype)
      else $error("illegal format reached the device");
   a_tex_opcode: assert property (
      (state_reg == ST_RUN && step_reg == P_DWG) |=>
         dev_data_o[W_OP+:4] == ($past(textured) ? OP_TEXTRAP : OP_TRAP) &&
         dev_data_o[W_ARZ] == $past(ctrl_reg[C_RECTANGLE_FILL]))
      else $error("opcode or rectangle flags wrong");
   a_pal_gate: assert property (
      (state_reg == ST_RUN && textured && (texel == TX_4 || texel == TX_8)) |->
         ctrl_reg[C_PAL])
      else $error("textured fill started without palette");
   a_zhi_gate: assert property (
      (dev_wr_o && dev_addr_o == D_Z32 + 14'h0004) |-> zw &&
         (ctrl_reg[C_ZCMP] || atype == AT_ZI))
      else $error("wide depth loaded without need");
endmodule // tfh_ctl

//--- tfh_pkg.sv
package tfh_pkg;
   // Operation
   // - Shift-zero set means no offset; load offset only when it is 0.
   // - Little-endian layout needs every pattern line stored twice.
   // - Block-write pattern fills need transparency 1; background only when 0.
   // - 24bpp pattern fills need raster access or byte-equal colours.
   // - Shaded fills use depth-interp or intensity access, never 24bpp.
   // - Depth values only with depth compare or depth-interp; wide as pairs.
   // - Texture fills load vertex colours only for modulate or decal.
   // - Texture fills never select 24bpp.
   // - 4 or 8 bit texels need the palette initialised first.
   // - Non power-of-two masks allow clamp addressing only.
   // - Mip-mapping needs masks of 16n-1 and pitch extension of 16n.
   // - Video scaler: perspective x/y increments zero, start 0x00010000.
   // - Drawing starts only on the final write in the alias range.

   localparam logic [7:0] A_CTRL = 8'h00, A_CMD = 8'h04, A_STAT = 8'h08;
   localparam logic [7:0] A_PATL = 8'h0c, A_PATH = 8'h10, A_FOREGROUND_COLOR_REG = 8'h14;
   localparam logic [7:0] A_BACKGROUND_COLOR_REG = 8'h18, A_SHIFT = 8'h1c, A_TEX = 8'h20;
   localparam logic [7:0] A_PARAM = 8'h40;
   localparam int N_PARAM = 20;
   localparam int C_MODE = 0, C_RECTANGLE_FILL = 3, C_SHZ = 4, C_TRC = 5, C_ATYPE = 6;
   localparam int C_PW = 9, C_FOG = 11, C_ZCMP = 12, C_ZW = 13, C_TFN = 14;
   localparam int C_PAL = 15, C_TEXEL = 16, C_MIP = 19, C_BIL = 20;
   localparam int C_BOP = 21, C_LE = 25, C_ZMODE = 26;
   localparam logic [31:0] CTRL_RST = 32'h0000_0010;
   localparam int T_WM = 0, T_HM = 11, T_CLAMP = 22, T_PEXT = 23;
   localparam int S_BUSY = 0, S_DONE = 1, S_ERR = 2, S_SPLIT = 7;
   localparam int W_OP = 0, W_AT = 4, W_ZM = 8, W_SOLID = 11, W_ARZ = 12;
   localparam int W_SGZ = 13, W_SHZ = 14, W_BOP = 16, W_TRC = 30;
   localparam logic [13:0] D_DWG = 14'h1c00, D_ALIAS = 14'h0100;
   localparam logic [13:0] D_MACC = 14'h1c04, D_PATTERN_WORD_LOW = 14'h1c10;
   localparam logic [13:0] D_PATTERN_WORD_HIGH = 14'h1c14, D_PATTERN_SOURCE_WORD_A = 14'h1c30;
   localparam logic [13:0] D_SHIFT = 14'h1c50, D_BACKGROUND_COLOR_REG = 14'h1c60;
   localparam logic [13:0] D_FOREGROUND_COLOR_REG = 14'h1c64, D_DR0 = 14'h1cc0;
   localparam logic [13:0] D_FOG = 14'h1c80, D_Z32 = 14'h2c00;
   localparam logic [13:0] D_TEXTURE_BASE_ORIGIN = 14'h2c20, D_PERSP_INC_X = 14'h2c30;
   localparam logic [13:0] D_PERSP_INC_Y = 14'h2c34, D_PERSP_START = 14'h2c40;
   localparam logic [13:0] D_RNG_LO = 14'h1d00, D_RNG_HI = 14'h1dff;
   localparam logic [3:0] OP_TRAP = 4'h4, OP_TEXTRAP = 4'h6, BOP_BLK = 4'hc;
   localparam logic [2:0] AT_RASTER_ACCESS = 3'h0, AT_ZI = 3'h3, AT_BLK = 3'h4;
   localparam logic [2:0] AT_I = 3'h7;
   localparam logic [1:0] PW_24 = 2'h3;
   localparam logic [2:0] TX_4 = 3'h0, TX_8 = 3'h1, TX_32 = 3'h3;
   localparam logic [2:0] TX_YUV = 3'h4;
   localparam logic [31:0] PERSP_START = 32'h0001_0000;
   localparam logic [31:0] PERSP_ZERO = 32'h0000_0000;
   localparam logic [11:0] SPLIT_TEXELS = 12'h200;
   localparam logic [3:0] MIP_LOW = 4'hf;
   localparam int PI_RGB = 0, PI_Z = 9, PI_ZHI = 12, PI_FOG = 15;
   localparam int PI_TEXTURE_BASE_ORIGIN = 19;
   typedef logic [5:0] tfh_step_t;
   localparam tfh_step_t P_MACC = 6'h00, P_PATTERN_WORD_LOW = 6'h01, P_PATTERN_WORD_HIGH = 6'h02;
   localparam tfh_step_t P_SRC = 6'h03, P_SHIFT = 6'h07, P_BACKGROUND_COLOR_REG = 6'h08;
   localparam tfh_step_t P_FOREGROUND_COLOR_REG = 6'h09, P_RGB = 6'h0a, P_Z = 6'h13;
   localparam tfh_step_t P_ZHI = 6'h16, P_FOG = 6'h19, P_TEXTURE_BASE_ORIGIN = 6'h1d;
   localparam tfh_step_t P_PERSP = 6'h1e, P_DWG = 6'h21;
   typedef enum logic [2:0] {
      M_PLAIN = 3'b000, M_PAT = 3'b001, M_GOUR = 3'b010,
      M_TEX = 3'b011, M_SCAL = 3'b100
   } tfh_mode_t;
   typedef enum logic {ST_IDLE = 1'b0, ST_RUN = 1'b1} tfh_state_t;
endpackage

//--- tfh_dev_model.sv
`timescale 1ns/10ps
module tfh_dev_model import tfh_pkg::*; (
   input wire logic clk_i, // Core clock
   input wire logic dev_wr_i, // Register write strobe
   input wire logic [13:0] dev_addr_i, // Register offset
   input wire logic [31:0] dev_data_i // Register data
);
   logic [31:0] regs [logic [13:0]];
   logic [31:0] last_dwg = 32'h0;
   logic [13:0] last_addr = 14'h0;
   int n_wr = 0;
   int n_start = 0;
   task automatic clear();
      regs.delete();
      n_start = 0;
   endtask
   // Colour of a pattern pixel; the offset only counts while shift-zero is clear
   function automatic logic [31:0] pixel(input int x, input int y);
      logic [63:0] pat;
      int ox;
      int oy;
      pat = {regs[D_PATTERN_WORD_HIGH], regs[D_PATTERN_WORD_LOW]};
      ox = last_dwg[W_SHZ] ? 0 : int'(regs[D_SHIFT][2:0]);
      oy = last_dwg[W_SHZ] ? 0 : int'(regs[D_SHIFT][5:3]);
      return pat[8 * ((y + oy) % 8) + 7 - ((x + ox) % 8)] ? regs[D_FOREGROUND_COLOR_REG] : regs[D_BACKGROUND_COLOR_REG];
   endfunction
   always @(posedge clk_i) begin
      if (dev_wr_i === 1'b1) begin
         // Shading, fog, texture origin and perspective values kept as loaded
         regs[dev_addr_i] = dev_data_i;
         n_wr++;
         last_addr = dev_addr_i;
         if (dev_addr_i >= D_RNG_LO && dev_addr_i <= D_RNG_HI) begin
            n_start++;
            last_dwg = dev_data_i;
         end
      end
   end
endmodule // tfh_dev_model

//--- tb.sv
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin fails++; $display("wrong value %s exp %h got %h", nm, ex, got); end end
module tb;
   import tfh_pkg::*;
   logic clk_i = 1'b0;
   logic resetn_i = 1'b0;
   logic sw_wr_i = 1'b0;
   logic sw_rd_i = 1'b0;
   logic [7:0] sw_addr_i = 8'h00;
   logic [31:0] sw_wdata_i = 32'h0;
   logic [31:0] sw_rdata_o;
   logic busy_o;
   logic dev_wr_o;
   logic [13:0] dev_addr_o;
   logic [31:0] dev_data_o;
   int fails = 0;
   int compares = 0;
   logic [13:0] qa [$];
   logic [31:0] qd [$];
   logic [31:0] p [20];
   logic [31:0] pl, ph, fg, bg, d, dwg;
   logic [63:0] pq;
   logic [31:0] ec [7] = '{32'h6c2, 32'h86c2, 32'h100c3, 32'h2, 32'h701, 32'h888c3, 32'h80c3};
   logic [31:0] et [7] = '{32'h7f8ff, 32'h7f8ff, 32'h7f8ff, 32'h7f8ff, 32'h7f8ff, 32'h7f810, 32'h7f805};
   int eb [7] = '{2, 2, 5, 4, 3, 6, 6};
   int n0;
   tfh_ctl u_dut (.clk_i(clk_i), .resetn_i(resetn_i), .sw_addr_i(sw_addr_i),
      .sw_wdata_i(sw_wdata_i), .sw_wr_i(sw_wr_i), .sw_rd_i(sw_rd_i), .sw_rdata_o(sw_rdata_o),
      .busy_o(busy_o), .dev_wr_o(dev_wr_o), .dev_addr_o(dev_addr_o), .dev_data_o(dev_data_o));
   tfh_dev_model u_dev (.clk_i(clk_i), .dev_wr_i(dev_wr_o), .dev_addr_i(dev_addr_o),
      .dev_data_i(dev_data_o));
   always #20 clk_i = ~clk_i;
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", compares, fails);
      if (fails == 0 && compares > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk_i);
      sw_wr_i <= 1'b1;
      sw_addr_i <= a;
      sw_wdata_i <= v;
      @(posedge clk_i);
      sw_wr_i <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge clk_i);
      sw_rd_i <= 1'b1;
      sw_addr_i <= a;
      @(posedge clk_i);
      sw_rd_i <= 1'b0;
      #1 v = sw_rdata_o;
   endtask
   task automatic exp(input logic [13:0] a, input logic [31:0] v);
      qa.push_back(a);
      qd.push_back(v);
   endtask
   // Shading registers land on the odd-spaced colour slots of the interpolator
   task automatic exp_rgb();
      int n [9] = '{4, 6, 7, 8, 10, 11, 12, 14, 15};
      foreach (n[i]) exp(D_DR0 + 14'(4 * n[i]), p[i]);
   endtask
   task automatic exp_z();
      exp(D_DR0, p[9]);
      exp(D_DR0 + 14'h8, p[10]);
      exp(D_DR0 + 14'hc, p[11]);
   endtask
   // Start, poke a config write while busy, wait, then check collected device writes
   task automatic run(input logic [31:0] ctrl);
      int k;
      u_dev.clear();
      wr(A_CMD, 32'h1);
      wr(A_CTRL, 32'hffffffff);
      for (k = 0; k < 80 && busy_o !== 1'b0; k++) @(posedge clk_i);
      #1;
      `CHK("busy", 1'b0, busy_o)
      `CHK("starts", 1, u_dev.n_start)
      `CHK("last addr", D_RNG_LO, u_dev.last_addr)
      foreach (qa[i]) `CHK("dev reg", qd[i], u_dev.regs[qa[i]])
      dwg = u_dev.last_dwg;
      rd(A_CTRL, d);
      `CHK("ctrl held", ctrl, d)
      rd(A_STAT, d);
      `CHK("done", 1'b1, d[S_DONE])
      wr(A_STAT, 32'h2);
      qa.delete();
      qd.delete();
   endtask
   initial begin
      #(40 * 20000);
      fails++;
      close_out();
   end
   initial begin
      void'($urandom(32'h6d899ea5));
      pl = $urandom();
      ph = $urandom();
      fg = $urandom();
      bg = $urandom();
      pq = {ph, pl};
      foreach (p[i]) p[i] = $urandom();
      repeat (12) @(posedge clk_i);
      resetn_i <= 1'b1;
      rd(A_CTRL, d);
      `CHK("ctrl reset", CTRL_RST, d)
      rd(8'hfc, d);
      `CHK("unmapped", 32'h0, d)
      foreach (p[i]) wr(A_PARAM + 8'(4 * i), p[i]);
      wr(A_PATL, pl);
      wr(A_PATH, ph);
      wr(A_FOREGROUND_COLOR_REG, fg);
      wr(A_BACKGROUND_COLOR_REG, bg);
      wr(A_SHIFT, 32'h15);
      // Two-word layout rectangle, raster access, opaque, offset 5,2
      wr(A_CTRL, 32'h9);
      exp(D_PATTERN_WORD_LOW, pl);
      exp(D_PATTERN_WORD_HIGH, ph);
      exp(D_FOREGROUND_COLOR_REG, fg);
      exp(D_BACKGROUND_COLOR_REG, bg);
      run(32'h9);
      `CHK("shift sent", 1'b1, u_dev.regs.exists(D_SHIFT))
      `CHK("opcode", OP_TRAP, dwg[3:0])
      `CHK("rectangle_fill flags", 2'b11, dwg[W_SGZ:W_ARZ])
      `CHK("shftzero", 1'b0, dwg[W_SHZ])
      // Offset 5,2 brings bit 18 to the first pixel of row 0
      for (int x = 0; x < 8; x++) `CHK("pixel", pq[8 * 2 + 7 - ((x + 5) % 8)] ? fg : bg, u_dev.pixel(x, 0))
      rd(A_STAT, d);
      `CHK("done clear", 1'b0, d[S_DONE])
      // Little-endian layout, block write, shift-zero set
      wr(A_CTRL, 32'h2000111);
      for (int j = 0; j < 4; j++) exp(D_PATTERN_SOURCE_WORD_A + 14'(4 * j), pq[16*j+8 +: 8] * 32'h01010000 | pq[16*j +: 8] * 32'h00000101);
      exp(D_FOREGROUND_COLOR_REG, fg);
      run(32'h2000111);
      `CHK("no shift", 1'b0, u_dev.regs.exists(D_SHIFT))
      `CHK("no background_color_reg", 1'b0, u_dev.regs.exists(D_BACKGROUND_COLOR_REG))
      `CHK("blk bop", BOP_BLK, dwg[W_BOP +: 4])
      `CHK("blk transc", 1'b1, dwg[W_TRC])
      `CHK("shftzero", 1'b1, dwg[W_SHZ])
      // Shaded fill with depth interpolation and fog
      wr(A_CTRL, 32'h8d2);
      exp_rgb();
      exp_z();
      for (int j = 0; j < 4; j++) exp(D_FOG + 14'(4 * j), p[15+j]);
      run(32'h8d2);
      `CHK("gour op", OP_TRAP, dwg[3:0])
      `CHK("gour at", AT_ZI, dwg[W_AT +: 3])
      // Textured fill, modulate, 8-bit texels with palette ready
      wr(A_TEX, 32'h7f8ff);
      wr(A_CTRL, 32'h1c0d3);
      exp_rgb();
      exp_z();
      exp(D_TEXTURE_BASE_ORIGIN, p[19]);
      run(32'h1c0d3);
      `CHK("tex op", OP_TEXTRAP, dwg[3:0])
      // Video scaler
      // 4-bit texels, so the palette flag must be set or the start is refused
      wr(A_CTRL, 32'h80d4);
      exp(D_PERSP_INC_X, PERSP_ZERO);
      exp(D_PERSP_INC_Y, PERSP_ZERO);
      exp(D_PERSP_START, PERSP_START);
      run(32'h80d4);
      `CHK("scal op", OP_TEXTRAP, dwg[3:0])
      // Wide bilinear 32-bit texels get the split advice
      wr(A_TEX, 32'h7fbff);
      wr(A_CTRL, 32'h1300d3);
      run(32'h1300d3);
      rd(A_STAT, d);
      `CHK("split", 1'b1, d[S_SPLIT])
      // Illegal setups are refused with no device traffic
      wr(A_FOREGROUND_COLOR_REG, 32'h12345678);
      foreach (ec[i]) begin
         wr(A_CTRL, ec[i]);
         wr(A_TEX, et[i]);
         n0 = u_dev.n_wr;
         wr(A_CMD, 32'h1);
         repeat (40) @(posedge clk_i);
         rd(A_STAT, d);
         `CHK("err bit", 1'b1, d[eb[i]])
         `CHK("no traffic", n0, u_dev.n_wr)
      end
      close_out();
   end
endmodule // tb
